/* pkg/acf_pkg.sv */
// Constants shared by the serial configuration bank and the output formatter.
package acf_pkg;

  // Serial word layout: address first, then data, one write per word.
  localparam int ADDR_W = 5;
  localparam int REG_W = 11;
  localparam int WORD_W = ADDR_W + REG_W;

  // Register addresses.
  localparam logic [4:0] ADDR_POWER = 5'h00;
  localparam logic [4:0] ADDR_TIMING = 5'h04;
  localparam logic [4:0] ADDR_ORDER = 5'h09;
  localparam logic [4:0] ADDR_PATTERN = 5'h0A;
  localparam logic [4:0] ADDR_USER_LO = 5'h0B;
  localparam logic [4:0] ADDR_USER_HI = 5'h0C;
  localparam logic [4:0] ADDR_LVDS = 5'h0E;
  localparam logic [4:0] ADDR_DRIVE = 5'h0F;

  // Every register comes out of reset as all zeros.
  localparam logic [10:0] REG_RESET = 11'h000;

  // Power, reset and interface control fields.
  localparam int BIT_STANDBY = 0;
  localparam int BIT_STROBE_OFF = 2;
  localparam int BIT_SOFT_RESET = 4;
  localparam int BIT_REF_EXT = 5;
  localparam int BIT_IF_LVDS = 8;
  localparam int BIT_COARSE_GAIN = 9;
  localparam int BIT_OUTPUTS_OFF = 10;

  // Output timing fields.
  localparam int BIT_STROBE_POSN = 8;
  localparam int BIT_CAPTURE_FALL = 9;
  localparam int BIT_DATA_POSN = 10;

  // Bit order, format and pattern fields.
  localparam int BIT_BYTE_WISE = 10;
  localparam int BIT_STRAIGHT_BIN = 10;
  localparam int PATTERN_LSB = 5;
  localparam int PATTERN_W = 3;
  localparam int USER_LO_LSB = 4;
  localparam int USER_LO_W = 7;
  localparam int USER_HI_LSB = 0;
  localparam int USER_HI_W = 5;
  localparam int FINE_GAIN_LSB = 8;
  localparam int FINE_GAIN_W = 3;
  localparam int LVDS_CFG_LSB = 0;
  localparam int LVDS_CFG_W = 10;
  localparam int DRIVE_LSB = 4;
  localparam int DRIVE_W = 4;

  // Test pattern codes.
  localparam logic [2:0] PAT_ADC = 3'h0;
  localparam logic [2:0] PAT_ZEROS = 3'h1;
  localparam logic [2:0] PAT_ONES = 3'h2;
  localparam logic [2:0] PAT_TOGGLE = 3'h3;
  localparam logic [2:0] PAT_RAMP = 3'h4;
  localparam logic [2:0] PAT_USER = 3'h5;

  // Fixed pattern words.
  localparam logic [13:0] WORD_ONES = 14'h3FFF;
  localparam logic [13:0] WORD_TOGGLE_A = 14'h2AAA;
  localparam logic [13:0] WORD_TOGGLE_B = 14'h1555;

  // Strobe delay: 400 ps, rounded up to whole reference clock cycles.
  localparam longint REF_CLK_HZ = 20_000_000;
  localparam longint STROBE_DELAY_PS = 400;
  localparam longint PS_PER_S = 1_000_000_000_000;
  localparam longint STROBE_DELAY_RAW = (STROBE_DELAY_PS * REF_CLK_HZ + PS_PER_S - 1) / PS_PER_S;
  localparam int STROBE_DELAY_CYC = (STROBE_DELAY_RAW < 1) ? 1 : int'(STROBE_DELAY_RAW);

endpackage : acf_pkg

/* rtl/acf_serial_rx.sv */
// Three-wire serial receiver that turns each 16-bit word into one register write.
`timescale 1ns/10ps
`default_nettype none

module acf_serial_rx
  import acf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial pins, asynchronous to clk
  input wire logic i_sel_n,
  input wire logic i_sclk,
  input wire logic i_serial_in_line,
  // Decoded write
  output logic o_valid,
  output logic [ADDR_W-1:0] o_addr,
  output logic [REG_W-1:0] o_data
);

  logic [2:0] sync_m;
  logic [2:0] sync_s;
  logic sclk_d;
  logic [WORD_W-2:0] shift;
  logic [3:0] count;
  logic next_valid;
  logic [ADDR_W-1:0] next_addr;
  logic [REG_W-1:0] next_data;
  logic [WORD_W-2:0] next_shift;
  logic [3:0] next_count;
  logic sclk_fall;

  // Only the second stage and its delayed copy feed the edge detector.
  assign sclk_fall = sclk_d & ~sync_s[1];

  always_comb begin
    next_valid = 1'b0;
    next_addr = o_addr;
    next_data = o_data;
    next_shift = shift;
    next_count = count;
    if (sync_s[2]) begin
      next_count = 4'h0;
    end else if (sclk_fall) begin
      next_shift = {shift[WORD_W-3:0], sync_s[0]};
      next_count = count + 4'h1;
      if (count == 4'hF) begin
        next_valid = 1'b1;
        next_addr = shift[WORD_W-2:REG_W-1];
        next_data = {shift[REG_W-2:0], sync_s[0]};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Both stages reset to the idle pins (select high, clock low), so no false clock edge follows reset.
      sync_m <= 3'h4;
      sync_s <= 3'h4;
      sclk_d <= 1'b0;
      shift <= '0;
      count <= 4'h0;
      o_valid <= 1'b0;
      o_addr <= '0;
      o_data <= '0;
    end else begin
      sync_m <= {i_sel_n, i_sclk, i_serial_in_line};
      sync_s <= sync_m;
      sclk_d <= sync_s[1];
      shift <= next_shift;
      count <= next_count;
      o_valid <= next_valid;
      o_addr <= next_addr;
      o_data <= next_data;
    end
  end

endmodule : acf_serial_rx

`default_nettype wire

/* rtl/acf_config_formatter.sv */
// Serial configuration bank and formatted sample output with strobe.
//
// Functional notes
// - Each serial word is 5 address bits then 11 data bits, one write.
// - All fields of one register written together take effect together.
// - Register 00 bit 0 puts only the converter core into standby.
// - Register 00 bit 2 powers down and tri-states the strobe only.
// - Register 00 bit 4 resets all registers; the bit self-clears.
// - Register 00 bit 10 disables both data and strobe output buffers.
// - Register 04 bit 8 delays the output strobe by 400 ps, rounded up to one reference clock cycle.
// - Strobe and data position bits are zero after reset, default timing.
// - Register 04 bit 9 picks the capture edge: zero rising, one falling.
// - Register 04 bit 10 delays data transitions by half a sample cycle.
// - Bit-wise DDR: even bits on strobe rising edge, odd on falling.
// - Byte-wise DDR: lower bit group on rising edge, upper on falling.
// - Pattern code 000 outputs converter samples; codes 110 and 111 unused.
// - Code 001 outputs all zeros; code 010 outputs all ones.
// - Code 011 alternates between 0x2AAA and 0x1555 each sample.
// - Code 100 outputs a ramp rising by one per sample, wrapping.
// - Code 101 outputs the user pattern.
// - User pattern: lower 7 bits from register 0B, next 5 from 0C, top 2 bits zero.
// - Register 0A bit 10: zero two's complement, one straight binary.
`timescale 1ns/10ps
`default_nettype none

module acf_config_formatter
  import acf_pkg::*;
#(
  parameter int DATA_W = 14
)
(
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RESETN,
  // Serial configuration port
  input wire logic I_SERIAL_SELECT_N,
  input wire logic I_SERIAL_CLK,
  input wire logic I_SERIAL_IN_LINE,
  // Sample clock and converter samples
  input wire logic I_SAMPLE_CLK,
  input wire logic [DATA_W-1:0] I_ADC_DATA,
  // Formatted output stream
  output logic [DATA_W-1:0] O_DATA,
  output logic [DATA_W/2-1:0] O_DDR_DATA,
  output logic O_DATA_OE_N,
  output logic O_OUTPUT_STROBE_TRUE,
  output logic O_STROBE_OE_N,
  // Static configuration
  output logic O_CORE_STANDBY,
  output logic O_REF_EXTERNAL,
  output logic O_LVDS_MODE,
  output logic O_COARSE_GAIN,
  output logic O_CAPTURE_FALLING,
  output logic [FINE_GAIN_W-1:0] O_FINE_GAIN,
  output logic [LVDS_CFG_W-1:0] O_LVDS_CONFIG,
  output logic [DRIVE_W-1:0] O_CMOS_DRIVE
);

  localparam int HALF_W = DATA_W / 2;

  if (DATA_W != 14) begin : g_width_check
    $error("DATA_W must be 14: fixed pattern words are 14 bits wide.");
  end

  // Converts a two's complement word when straight binary is selected.
  function automatic logic [DATA_W-1:0] to_format(input logic [DATA_W-1:0] w, input logic straight);
    to_format = straight ? {~w[DATA_W-1], w[DATA_W-2:0]} : w;
  endfunction : to_format

  // Configuration registers
  logic [REG_W-1:0] reg_power;
  logic [REG_W-1:0] reg_timing;
  logic [REG_W-1:0] reg_order;
  logic [REG_W-1:0] reg_pattern;
  logic [REG_W-1:0] reg_user_lo;
  logic [REG_W-1:0] reg_user_hi;
  logic [REG_W-1:0] reg_lvds;
  logic [REG_W-1:0] reg_drive;
  logic [REG_W-1:0] next_power;
  logic [REG_W-1:0] next_timing;
  logic [REG_W-1:0] next_order;
  logic [REG_W-1:0] next_pattern;
  logic [REG_W-1:0] next_user_lo;
  logic [REG_W-1:0] next_user_hi;
  logic [REG_W-1:0] next_lvds;
  logic [REG_W-1:0] next_drive;
  logic wr_valid;
  logic [ADDR_W-1:0] wr_addr;
  logic [REG_W-1:0] wr_data;

  acf_serial_rx u_serial_rx (
    .clk(I_REF_CLK),
    .rst_n(I_RESETN),
    .i_sel_n(I_SERIAL_SELECT_N),
    .i_sclk(I_SERIAL_CLK),
    .i_serial_in_line(I_SERIAL_IN_LINE),
    .o_valid(wr_valid),
    .o_addr(wr_addr),
    .o_data(wr_data)
  );

  // A whole register word lands in one cycle, so every field in it changes together.
  always_comb begin
    next_power = reg_power;
    next_timing = reg_timing;
    next_order = reg_order;
    next_pattern = reg_pattern;
    next_user_lo = reg_user_lo;
    next_user_hi = reg_user_hi;
    next_lvds = reg_lvds;
    next_drive = reg_drive;
    if (wr_valid) begin
      if (wr_addr == ADDR_POWER && wr_data[BIT_SOFT_RESET]) begin
        next_power = REG_RESET;
        next_timing = REG_RESET;
        next_order = REG_RESET;
        next_pattern = REG_RESET;
        next_user_lo = REG_RESET;
        next_user_hi = REG_RESET;
        next_lvds = REG_RESET;
        next_drive = REG_RESET;
      end else begin
        unique case (wr_addr)
          ADDR_POWER: next_power = wr_data;
          ADDR_TIMING: next_timing = wr_data;
          ADDR_ORDER: next_order = wr_data;
          ADDR_PATTERN: next_pattern = wr_data;
          ADDR_USER_LO: next_user_lo = wr_data;
          ADDR_USER_HI: next_user_hi = wr_data;
          ADDR_LVDS: next_lvds = wr_data;
          ADDR_DRIVE: next_drive = wr_data;
          default: next_power = reg_power;
        endcase
      end
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      reg_power <= REG_RESET;
      reg_timing <= REG_RESET;
      reg_order <= REG_RESET;
      reg_pattern <= REG_RESET;
      reg_user_lo <= REG_RESET;
      reg_user_hi <= REG_RESET;
      reg_lvds <= REG_RESET;
      reg_drive <= REG_RESET;
    end else begin
      reg_power <= next_power;
      reg_timing <= next_timing;
      reg_order <= next_order;
      reg_pattern <= next_pattern;
      reg_user_lo <= next_user_lo;
      reg_user_hi <= next_user_hi;
      reg_lvds <= next_lvds;
      reg_drive <= next_drive;
    end
  end

  // The self-clearing reset bit is never stored, so it always reads back as zero.
  assign O_CORE_STANDBY = reg_power[BIT_STANDBY];
  assign O_REF_EXTERNAL = reg_power[BIT_REF_EXT];
  assign O_LVDS_MODE = reg_power[BIT_IF_LVDS];
  assign O_COARSE_GAIN = reg_power[BIT_COARSE_GAIN];
  assign O_CAPTURE_FALLING = reg_timing[BIT_CAPTURE_FALL];
  assign O_FINE_GAIN = reg_user_hi[FINE_GAIN_LSB +: FINE_GAIN_W];
  assign O_LVDS_CONFIG = reg_lvds[LVDS_CFG_LSB +: LVDS_CFG_W];
  assign O_CMOS_DRIVE = reg_drive[DRIVE_LSB +: DRIVE_W];

  // Sample clock and converter data synchronisers
  logic samp_m;
  logic samp_s;
  logic samp_d;
  logic [DATA_W-1:0] adc_m;
  logic [DATA_W-1:0] adc_s;
  logic samp_rise;
  logic samp_fall;

  assign samp_rise = samp_s & ~samp_d;
  assign samp_fall = samp_d & ~samp_s;

  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      samp_m <= 1'b0;
      samp_s <= 1'b0;
      samp_d <= 1'b0;
      adc_m <= '0;
      adc_s <= '0;
    end else begin
      samp_m <= I_SAMPLE_CLK;
      samp_s <= samp_m;
      samp_d <= samp_s;
      adc_m <= I_ADC_DATA;
      adc_s <= adc_m;
    end
  end

  // Bit-wise lanes: even bits of the word being launched, odd bits of the word already on the bus.
  logic [HALF_W-1:0] even_bits;
  logic [HALF_W-1:0] odd_bits;
  logic [DATA_W-1:0] held_word;
  logic [DATA_W-1:0] launch_word;

  for (genvar i = 0; i < HALF_W; i++) begin : g_bit_lanes
    assign even_bits[i] = launch_word[2*i];
    assign odd_bits[i] = held_word[2*i+1];
  end

  // Data path state
  logic [DATA_W-1:0] ramp;
  logic toggle_b;
  logic [DATA_W-1:0] core_sample;
  logic [DATA_W-1:0] next_ramp;
  logic next_toggle_b;
  logic [DATA_W-1:0] next_core_sample;
  logic [DATA_W-1:0] next_held_word;
  logic [DATA_W-1:0] staged_word;
  logic [DATA_W-1:0] next_staged_word;
  logic [DATA_W-1:0] next_data;
  logic [HALF_W-1:0] next_ddr;
  logic [DATA_W-1:0] pattern_word;
  logic [DATA_W-1:0] user_word;
  logic launch_first;
  logic launch_second;
  logic byte_wise;

  assign user_word = DATA_W'({reg_user_hi[USER_HI_LSB +: USER_HI_W],
                              reg_user_lo[USER_LO_LSB +: USER_LO_W]});
  assign byte_wise = reg_order[BIT_BYTE_WISE];
  // With the data position bit set, words launch on the falling sample edge instead.
  assign launch_first = reg_timing[BIT_DATA_POSN] ? samp_fall : samp_rise;
  assign launch_second = reg_timing[BIT_DATA_POSN] ? samp_rise : samp_fall;
  // A late launch sends the word staged at the rising edge, so no word is skipped or sent early.
  assign launch_word = reg_timing[BIT_DATA_POSN] ? staged_word : pattern_word;

  always_comb begin
    unique case (reg_pattern[PATTERN_LSB +: PATTERN_W])
      PAT_ADC: pattern_word = to_format(core_sample, reg_pattern[BIT_STRAIGHT_BIN]);
      PAT_ZEROS: pattern_word = '0;
      PAT_ONES: pattern_word = WORD_ONES;
      PAT_TOGGLE: pattern_word = toggle_b ? WORD_TOGGLE_B : WORD_TOGGLE_A;
      PAT_RAMP: pattern_word = ramp;
      PAT_USER: pattern_word = user_word;
      default: pattern_word = '0;
    endcase
  end

  always_comb begin
    next_ramp = ramp;
    next_toggle_b = toggle_b;
    next_core_sample = core_sample;
    next_held_word = held_word;
    next_staged_word = staged_word;
    next_data = O_DATA;
    next_ddr = O_DDR_DATA;
    if (samp_rise) begin
      next_staged_word = pattern_word;
      next_ramp = ramp + DATA_W'(1);
      next_toggle_b = ~toggle_b;
      // In standby the core delivers no new conversions; the last one is held.
      if (!reg_power[BIT_STANDBY]) begin
        next_core_sample = adc_s;
      end
    end
    if (launch_first) begin
      next_held_word = launch_word;
      next_data = launch_word;
      next_ddr = byte_wise ? launch_word[HALF_W-1:0] : even_bits;
    end else if (launch_second) begin
      next_ddr = byte_wise ? held_word[DATA_W-1:HALF_W] : odd_bits;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ramp <= '0;
      toggle_b <= 1'b0;
      core_sample <= '0;
      held_word <= '0;
      staged_word <= '0;
      O_DATA <= '0;
      O_DDR_DATA <= '0;
    end else begin
      ramp <= next_ramp;
      toggle_b <= next_toggle_b;
      core_sample <= next_core_sample;
      held_word <= next_held_word;
      staged_word <= next_staged_word;
      O_DATA <= next_data;
      O_DDR_DATA <= next_ddr;
    end
  end

  // Strobe generation: the 400 ps shift is coarsened to whole reference cycles, which
  // is the finest step this single-clock design can offer.
  logic [STROBE_DELAY_CYC-1:0] strobe_pipe;
  logic strobe_base;
  logic next_strobe;
  logic next_data_oe_n;
  logic next_strobe_oe_n;

  assign strobe_base = reg_timing[BIT_STROBE_POSN] ? strobe_pipe[STROBE_DELAY_CYC-1] : samp_d;

  always_comb begin
    next_strobe = strobe_base ^ reg_timing[BIT_CAPTURE_FALL];
    next_data_oe_n = reg_power[BIT_OUTPUTS_OFF];
    next_strobe_oe_n = reg_power[BIT_OUTPUTS_OFF] | reg_power[BIT_STROBE_OFF];
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      strobe_pipe <= '0;
      O_OUTPUT_STROBE_TRUE <= 1'b0;
      O_DATA_OE_N <= 1'b0;
      O_STROBE_OE_N <= 1'b0;
    end else begin
      strobe_pipe <= STROBE_DELAY_CYC'({strobe_pipe, samp_d});
      O_OUTPUT_STROBE_TRUE <= next_strobe;
      O_DATA_OE_N <= next_data_oe_n;
      O_STROBE_OE_N <= next_strobe_oe_n;
    end
  end

endmodule : acf_config_formatter

`default_nettype wire

/* testbench/acf_properties.sv */
// Port-level checks for the configuration bank and output formatter.
`timescale 1ns/10ps
`default_nettype none

module acf_properties #(
  parameter int DATA_W = 14
)
(
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RESETN,
  // Watched inputs
  input wire logic I_SERIAL_SELECT_N,
  input wire logic I_SAMPLE_CLK,
  // Watched outputs
  input wire logic [DATA_W-1:0] O_DATA,
  input wire logic [DATA_W/2-1:0] O_DDR_DATA,
  input wire logic O_DATA_OE_N,
  input wire logic O_OUTPUT_STROBE_TRUE,
  input wire logic O_STROBE_OE_N,
  input wire logic O_CORE_STANDBY,
  input wire logic O_REF_EXTERNAL,
  input wire logic O_LVDS_MODE,
  input wire logic O_COARSE_GAIN,
  input wire logic O_CAPTURE_FALLING
);
  logic [3:0] sel_age;
  logic [3:0] smp_age;
  logic smp_q;
  logic [DATA_W/2-1:0] ev;
  logic [DATA_W/2-1:0] od;

  // Ages saturate so that long idle stretches never wrap back into the window.
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      sel_age <= 4'h0;
      smp_age <= 4'h0;
      smp_q <= 1'b0;
    end else begin
      smp_q <= I_SAMPLE_CLK;
      sel_age <= !I_SERIAL_SELECT_N ? 4'h0 : (sel_age == 4'hF) ? sel_age : sel_age + 4'h1;
      smp_age <= (I_SAMPLE_CLK != smp_q) ? 4'h0 : (smp_age == 4'hF) ? smp_age : smp_age + 4'h1;
    end
  end

  always_comb begin
    for (int k = 0; k < DATA_W / 2; k++) begin
      ev[k] = O_DATA[2*k];
      od[k] = O_DATA[2*k+1];
    end
  end

  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESETN);

  oe_pair_a: assert property (O_DATA_OE_N |-> O_STROBE_OE_N)
    else $error("data buffers off while strobe buffer on");
  cfg_quiet_a: assert property ($changed({O_CORE_STANDBY, O_REF_EXTERNAL, O_LVDS_MODE, O_COARSE_GAIN,
    O_CAPTURE_FALLING}) |-> sel_age < 4'hC) else $error("static output moved without a serial write");
  strobe_oe_quiet_a: assert property ($changed({O_STROBE_OE_N, O_DATA_OE_N}) |-> sel_age < 4'hC)
    else $error("buffer enable moved without a serial write");
  data_after_sample_a: assert property ($changed(O_DATA) |-> smp_age < 4'h6 || sel_age < 4'hC)
    else $error("data word moved without a sample edge");
  strobe_rise_a: assert property ($rose(I_SAMPLE_CLK) && !O_CAPTURE_FALLING && !O_STROBE_OE_N
    |-> ##[1:6] $rose(O_OUTPUT_STROBE_TRUE)) else $error("strobe did not rise after sample edge");
  strobe_fall_a: assert property ($rose(I_SAMPLE_CLK) && O_CAPTURE_FALLING && !O_STROBE_OE_N
    |-> ##[1:6] $fell(O_OUTPUT_STROBE_TRUE)) else $error("inverted strobe did not fall");
  // Both lane checks assume the default data position while the lane is in use.
  ddr_first_a: assert property (O_LVDS_MODE && $changed(O_DDR_DATA) && I_SAMPLE_CLK
    |-> O_DDR_DATA == O_DATA[DATA_W/2-1:0] || O_DDR_DATA == ev) else $error("wrong first lane half");
  ddr_second_a: assert property (O_LVDS_MODE && $changed(O_DDR_DATA) && !I_SAMPLE_CLK
    |-> O_DDR_DATA == O_DATA[DATA_W-1:DATA_W/2] || O_DDR_DATA == od) else $error("wrong second lane half");
endmodule : acf_properties
`default_nettype wire

/* testbench/acf_capture_model.sv */
// Receiver capture logic on the far side of the formatted output bus.
`timescale 1ns/10ps
`default_nettype none

module acf_capture_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus as seen at the receiver pins
  input wire logic strobe,
  input wire logic [13:0] data,
  input wire logic fall,
  // Captured words
  output logic [13:0] o_word,
  output logic [15:0] o_count
);
  logic strobe_q;

  // Oversampled on the reference clock, so a bus that is only updated on that clock is read race-free.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_q <= 1'b0;
      o_word <= '0;
      o_count <= '0;
    end else begin
      strobe_q <= strobe;
      if (strobe != strobe_q && strobe == !fall) begin
        o_word <= data;
        o_count <= o_count + 16'h1;
      end
    end
  end
endmodule : acf_capture_model
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the configuration bank and output formatter.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import acf_pkg::*;
  logic clk, rstn, sel_n, sclk, sdi, smp, str, doe_n, soe_n, stby, refx, lvds, cg, cf;
  logic [13:0] adc, dat, cap;
  logic [6:0] ddr;
  logic [2:0] fg;
  logic [9:0] lcfg;
  logic [3:0] drv;
  logic [15:0] ncap;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;

  acf_config_formatter i_dut (.I_REF_CLK(clk), .I_RESETN(rstn), .I_SERIAL_SELECT_N(sel_n), .I_SERIAL_CLK(sclk),
    .I_SERIAL_IN_LINE(sdi), .I_SAMPLE_CLK(smp), .I_ADC_DATA(adc), .O_DATA(dat), .O_DDR_DATA(ddr),
    .O_DATA_OE_N(doe_n), .O_OUTPUT_STROBE_TRUE(str), .O_STROBE_OE_N(soe_n), .O_CORE_STANDBY(stby),
    .O_REF_EXTERNAL(refx), .O_LVDS_MODE(lvds), .O_COARSE_GAIN(cg), .O_CAPTURE_FALLING(cf), .O_FINE_GAIN(fg),
    .O_LVDS_CONFIG(lcfg), .O_CMOS_DRIVE(drv));

  // A released strobe falls to its pull-down; released data shows the inverse of the word on O_DATA, which keeps updating.
  acf_capture_model i_cap (.clk(clk), .rst_n(rstn), .strobe(soe_n ? 1'b0 : str), .data(doe_n ? ~dat : dat),
    .fall(cf), .o_word(cap), .o_count(ncap));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Serial clock idles low between words, at a 400 ns period.
  task automatic wr(input logic [4:0] a, input logic [10:0] d);
    logic [15:0] w;
    w = {a, d};
    sel_n <= 1'b0;
    tick(4);
    for (int i = 15; i >= 0; i--) begin
      sdi <= w[i];
      sclk <= 1'b1;
      tick(4);
      sclk <= 1'b0;
      tick(4);
    end
    tick(2);
    sel_n <= 1'b1;
    sdi <= ~sdi;
    tick(8);
  endtask : wr

  task automatic smp_cyc(input int n);
    repeat (n) begin
      smp <= 1'b1;
      tick(6);
      smp <= 1'b0;
      tick(6);
    end
  endtask : smp_cyc

  task automatic lag(output int n);
    n = 0;
    smp <= 1'b1;
    do begin
      tick(1);
      n++;
    end while (str !== 1'b1 && n < 20);
    tick(6);
    smp <= 1'b0;
    tick(8);
  endtask : lag

  task automatic conclude;
    if (error_cnt == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  initial begin
    logic [13:0] a, w;
    logic [6:0] ev, od;
    logic [3:0] codes [4];
    logic [13:0] pexp [8];
    int d0, d1, n0;
    codes = '{4'h0, 4'h5, 4'hF, 4'hA};
    pexp = '{14'h0, 14'h0, WORD_ONES, 14'h0, 14'h0, 14'h09DA, 14'h0, 14'h0};
    w = 14'h09DA;
    rstn = 1'b0;
    sel_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    smp = 1'b0;
    adc = 14'h2345;
    tick(6);
    rstn <= 1'b1;
    tick(2);
    chk(14'({stby, refx, lvds, cg, cf, doe_n, soe_n}), 14'h0);
    wr(ADDR_POWER, 11'h321);
    chk(14'({stby, refx, lvds, cg}), 14'hF);
    wr(ADDR_USER_HI, 11'h500);
    wr(ADDR_LVDS, 11'h2A5);
    wr(5'h1F, 11'h7FF);
    chk(14'({fg, lcfg}), 14'h16A5);
    foreach (codes[i]) begin
      wr(ADDR_DRIVE, {3'h0, codes[i], 4'h0});
      chk(14'(drv), 14'(codes[i]));
    end
    wr(ADDR_POWER, 11'h010);
    chk(14'({stby, refx, lvds, cg, fg, drv}), 14'h0);
    chk(14'(lcfg), 14'h0);
    wr(ADDR_POWER, 11'h400);
    chk(14'({doe_n, soe_n}), 14'h3);
    wr(ADDR_USER_LO, 11'h5A0);
    wr(ADDR_USER_HI, 11'h013);
    for (int k = 1; k < 8; k++) begin
      if (k == 3 || k == 4)
        continue;
      wr(ADDR_PATTERN, 11'(k) << PATTERN_LSB);
      smp_cyc(2);
      chk(dat, pexp[k]);
    end
    wr(ADDR_POWER, 11'h000);
    for (int k = 3; k < 5; k++) begin
      wr(ADDR_PATTERN, 11'(k) << PATTERN_LSB);
      smp_cyc(2);
      a = cap;
      smp_cyc(1);
      chk(cap, (k == 3) ? a ^ 14'h3FFF : a + 14'h1);
      if (k == 3)
        chk(14'(a inside {WORD_TOGGLE_A, WORD_TOGGLE_B}), 14'h1);
    end
    wr(ADDR_POWER, 11'h004);
    chk(14'({doe_n, soe_n}), 14'h1);
    n0 = ncap;
    a = dat;
    smp_cyc(2);
    chk(14'(ncap - n0), 14'h0);
    chk(dat, a + 14'h2);
    wr(ADDR_POWER, 11'h000);
    wr(ADDR_TIMING, 11'h200);
    n0 = ncap;
    a = dat;
    smp_cyc(2);
    chk(14'(ncap - n0), 14'h2);
    chk(cap, a + 14'h2);
    wr(ADDR_TIMING, 11'h000);
    lag(d0);
    wr(ADDR_TIMING, 11'h100);
    lag(d1);
    chk(14'(d1 - d0), 14'(STROBE_DELAY_CYC));
    wr(ADDR_TIMING, 11'h400);
    a = dat;
    smp <= 1'b1;
    tick(6);
    chk(dat, a);
    smp <= 1'b0;
    tick(6);
    chk(dat, a + 14'h1);
    wr(ADDR_TIMING, 11'h000);
    wr(ADDR_PATTERN, 11'h000);
    smp_cyc(1);
    chk(dat, 14'h2345);
    wr(ADDR_PATTERN, 11'h400);
    smp_cyc(1);
    chk(dat, 14'h0345);
    wr(ADDR_POWER, 11'h001);
    adc <= 14'h1111;
    smp_cyc(2);
    chk(dat, 14'h0345);
    wr(ADDR_POWER, 11'h000);
    smp_cyc(2);
    chk(dat, 14'h3111);
    wr(ADDR_POWER, 11'h100);
    wr(ADDR_PATTERN, 11'(PAT_USER) << PATTERN_LSB);
    for (int j = 0; j < 7; j++) begin
      ev[j] = w[2*j];
      od[j] = w[2*j+1];
    end
    for (int o = 0; o < 2; o++) begin
      wr(ADDR_ORDER, 11'(o) << BIT_BYTE_WISE);
      smp <= 1'b1;
      tick(6);
      chk(14'(ddr), 14'(o ? w[6:0] : ev));
      smp <= 1'b0;
      tick(6);
      chk(14'(ddr), 14'(o ? w[13:7] : od));
    end
    conclude();
  end
endmodule : testbench

bind acf_config_formatter acf_properties #(.DATA_W(DATA_W)) i_props (.I_REF_CLK(I_REF_CLK), .I_RESETN(I_RESETN),
  .I_SERIAL_SELECT_N(I_SERIAL_SELECT_N), .I_SAMPLE_CLK(I_SAMPLE_CLK), .O_DATA(O_DATA), .O_DDR_DATA(O_DDR_DATA),
  .O_DATA_OE_N(O_DATA_OE_N), .O_OUTPUT_STROBE_TRUE(O_OUTPUT_STROBE_TRUE), .O_STROBE_OE_N(O_STROBE_OE_N),
  .O_CORE_STANDBY(O_CORE_STANDBY), .O_REF_EXTERNAL(O_REF_EXTERNAL), .O_LVDS_MODE(O_LVDS_MODE),
  .O_COARSE_GAIN(O_COARSE_GAIN), .O_CAPTURE_FALLING(O_CAPTURE_FALLING));
`default_nettype wire
